// ==== verilog/resource_routing.sv ====
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module resource_routing (
	input  wire logic                                aclk,
	input  wire logic                                aresetn,
	input  wire logic [11:0]                         s_axi_awaddr,
	input  wire logic                                s_axi_awvalid,
	output logic                                     s_axi_awready,
	input  wire logic [31:0]                         s_axi_wdata,
	input  wire logic [3:0]                          s_axi_wstrb,
	input  wire logic                                s_axi_wvalid,
	output logic                                     s_axi_wready,
	output logic [1:0]                               s_axi_bresp,
	output logic                                     s_axi_bvalid,
	input  wire logic                                s_axi_bready,
	input  wire logic [11:0]                         s_axi_araddr,
	input  wire logic                                s_axi_arvalid,
	output logic                                     s_axi_arready,
	output logic [31:0]                              s_axi_rdata,
	output logic [1:0]                               s_axi_rresp,
	output logic                                     s_axi_rvalid,
	input  wire logic                                s_axi_rready,
	input  wire logic [11:0]                         io_addr,
	input  wire logic                                io_strobe,
	input  wire logic [3:0]                          dack_pins,
	input  wire resource_routing_pkg::func_status_t  status,
	input  wire resource_routing_pkg::func_req_t     req,
	output logic [5:0]                               io_sel,
	output logic [11:0]                              io_offset,
	output logic [5:0]                               dev_powered,
	output logic                                     epp_ok,
	output logic [15:0]                              irq_out,
	output logic [15:0]                              irq_oe,
	output logic [3:0]                               drq_out,
	output logic [3:0]                               drq_oe,
	output logic [5:0]                               dack_dev
);

	// ***************************************************
	// state
	// ***************************************************
	resource_routing_pkg::state_t q;
	resource_routing_pkg::state_t d;

	logic [5:0]       base_valid;
	logic [5:0]       dev_on;
	logic [5:0]       addr_hit;
	logic [5:0][11:0] rel;
	logic [5:0]       irq_en;
	logic [5:0]       dma_en;
	logic             wr_fire;
	logic [3:0]       cur_w;
	logic [3:0]       cur_r;

	function automatic logic [3:0] find_dev(input logic [7:0] ldn);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < resource_routing_pkg::NDEV; i++) begin
			if (resource_routing_pkg::LDN_NUM[i] == ldn) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic base_ok(input int unsigned dv, input logic [15:0] b);
		logic r;
		r = 1'b0;
		case (dv)
			resource_routing_pkg::DEV_PP: begin
				r = (b >= resource_routing_pkg::STD_MIN) && (b <= resource_routing_pkg::PP_MAX)
					&& (b[1:0] == 2'h0);
			end
			resource_routing_pkg::DEV_KBD: begin
				r = 1'b1;
			end
			resource_routing_pkg::DEV_PM: begin
				r = (b <= resource_routing_pkg::PM_MAX)
					&& ((b % resource_routing_pkg::PM_SPAN) == 16'h0000);
			end
			default: begin
				r = (b >= resource_routing_pkg::STD_MIN) && (b <= resource_routing_pkg::STD_MAX)
					&& (b[2:0] == 3'h0);
			end
		endcase
		return r;
	endfunction

	function automatic logic match(input int unsigned dv, input logic [11:0] a,
			input logic [15:0] b, input logic [11:0] r);
		logic m;
		m = 1'b0;
		case (dv)
			resource_routing_pkg::DEV_PP: begin
				// a 4-aligned base only gets the first four offsets; enhanced needs eight
				m = (b[2] ? (a[11:2] == b[11:2]) : (a[11:3] == b[11:3]))
					|| ((r >= resource_routing_pkg::PP_EXT_OFS)
					&& (r <= resource_routing_pkg::PP_EXT_LAST));
			end
			resource_routing_pkg::DEV_KBD: begin
				m = (a == resource_routing_pkg::KBD_DATA) || (a == resource_routing_pkg::KBD_DATA
					+ resource_routing_pkg::KBD_CMD_OFS);
			end
			resource_routing_pkg::DEV_PM: begin
				m = ({4'h0, r} < resource_routing_pkg::PM_SPAN);
			end
			default: begin
				m = (a[11:3] == b[11:3]);
			end
		endcase
		return m;
	endfunction

	function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [3:0] c,
			input resource_routing_pkg::state_t s);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			resource_routing_pkg::IDX_LDN: v = s.ldn;
			resource_routing_pkg::IDX_PWR: v = {2'h0, s.act};
			resource_routing_pkg::IDX_ACT: v = c[3] ? {7'h00, s.act[c[2:0]]} : 8'h00;
			resource_routing_pkg::IDX_BASE_HI: v = c[3] ? s.base[c[2:0]][15:8] : 8'h00;
			resource_routing_pkg::IDX_BASE_LO: v = c[3] ? s.base[c[2:0]][7:0] : 8'h00;
			resource_routing_pkg::IDX_IRQ: v = c[3] ? {4'h0, s.irq_sel[c[2:0]]} : 8'h00;
			resource_routing_pkg::IDX_DMA: v = c[3] ? {5'h00, s.dma_sel[c[2:0]]} : 8'h00;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// ***************************************************
	// per-device decode
	// ***************************************************
	generate
		for (genvar g = 0; g < resource_routing_pkg::NDEV; g++) begin : g_dev
			// 12-bit difference: upper host bits never take part
			assign rel[g] = q.a_sync2 - q.base[g][11:0];
			assign base_valid[g] = base_ok(g, q.base[g]);
			assign dev_on[g] = q.act[g] && base_valid[g];
			assign addr_hit[g] = dev_on[g] && q.s_sync2 && match(g, q.a_sync2, q.base[g], rel[g]);
		end
	endgenerate

	// ***************************************************
	// function enables
	// ***************************************************
	always_comb begin
		logic pp_on;
		pp_on = (status.ecp_mode == resource_routing_pkg::ECP_FIFO)
			|| (status.ecp_mode == resource_routing_pkg::ECP_ECP)
			|| (status.ecp_mode == resource_routing_pkg::ECP_TEST);
		irq_en = 6'h00;
		dma_en = 6'h00;
		irq_en[resource_routing_pkg::DEV_FDC] = status.floppy_dma_enable;
		if (status.ecp_mode_on) begin
			irq_en[resource_routing_pkg::DEV_PP] = (pp_on || status.printer_irq_enable)
				&& !status.ecp_service_interrupt;
		end else begin
			irq_en[resource_routing_pkg::DEV_PP] = status.printer_irq_enable;
		end
		irq_en[resource_routing_pkg::DEV_SP1] = (|status.uart_int_enable_reg[0])
			&& status.modem_aux_output_two[0];
		irq_en[resource_routing_pkg::DEV_SP2] = (|status.uart_int_enable_reg[1])
			&& status.modem_aux_output_two[1];
		irq_en[resource_routing_pkg::DEV_KBD] = status.kbd_irq_enable;
		irq_en[resource_routing_pkg::DEV_PM] = 1'b1;
		dma_en[resource_routing_pkg::DEV_FDC] = status.floppy_dma_enable;
		dma_en[resource_routing_pkg::DEV_PP] = status.ecp_dma_enable;
		dma_en[resource_routing_pkg::DEV_SP2] = status.uart2_dma_enable;
		for (int i = 0; i < resource_routing_pkg::NDEV; i++) begin
			// activate and base checks stack on top of the function's own bits
			irq_en[i] = irq_en[i] && dev_on[i] && (q.irq_sel[i] != 4'h0);
			dma_en[i] = dma_en[i] && dev_on[i] && resource_routing_pkg::HAS_DMA[i]
				&& !q.dma_sel[i][2];
		end
	end

	// ***************************************************
	// bus slave and next state
	// ***************************************************
	assign s_axi_awready = !q.aw_held;
	assign s_axi_wready  = !q.w_held;
	assign s_axi_arready = !q.rvalid;
	assign wr_fire       = q.aw_held && q.w_held && !q.bvalid;
	assign cur_w         = find_dev(q.ldn);
	assign cur_r         = find_dev(q.ldn);

	always_comb begin
		logic [7:0] idx;
		logic [2:0] c;
		idx = q.awaddr[9:2];
		c = cur_w[2:0];
		d = q;
		// host pins are asynchronous; the host holds the address through the strobe
		d.a_sync1 = io_addr;
		d.a_sync2 = q.a_sync1;
		d.s_sync1 = io_strobe;
		d.s_sync2 = q.s_sync1;
		d.k_sync1 = dack_pins;
		d.k_sync2 = q.k_sync1;
		if (s_axi_awvalid && !q.aw_held) begin
			d.aw_held = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_held) begin
			d.w_held = 1'b1;
			d.wdata = s_axi_wdata[7:0];
			d.wstrb0 = s_axi_wstrb[0];
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			d.aw_held = 1'b0;
			d.w_held = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = (q.awaddr[11:10] != 2'h0) ? resource_routing_pkg::RESP_SLVERR
				: resource_routing_pkg::RESP_OKAY;
			if (q.awaddr[11:10] == 2'h0 && q.wstrb0) begin
				case (idx)
					resource_routing_pkg::IDX_LDN: d.ldn = q.wdata;
					// one stored bit per device serves both activate and power control
					resource_routing_pkg::IDX_PWR: d.act = q.wdata[5:0];
					resource_routing_pkg::IDX_ACT: begin
						if (cur_w[3]) begin
							d.act[c] = q.wdata[0];
						end
					end
					resource_routing_pkg::IDX_BASE_HI: begin
						if (cur_w[3] && resource_routing_pkg::RELOCATABLE[c]) begin
							d.base[c][15:8] = q.wdata;
						end
					end
					resource_routing_pkg::IDX_BASE_LO: begin
						if (cur_w[3] && resource_routing_pkg::RELOCATABLE[c]) begin
							d.base[c][7:0] = q.wdata;
						end
					end
					resource_routing_pkg::IDX_IRQ: begin
						if (cur_w[3]) begin
							d.irq_sel[c] = q.wdata[3:0];
						end
					end
					resource_routing_pkg::IDX_DMA: begin
						if (cur_w[3] && resource_routing_pkg::HAS_DMA[c]) begin
							d.dma_sel[c] = q.wdata[2:0];
						end
					end
					default: begin
					end
				endcase
			end
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp = (s_axi_araddr[11:10] != 2'h0) ? resource_routing_pkg::RESP_SLVERR
				: resource_routing_pkg::RESP_OKAY;
			d.rdata = (s_axi_araddr[11:10] != 2'h0) ? 8'h00
				: reg_read(s_axi_araddr[9:2], cur_r, q);
		end
		// host decode: at most one device matches a legal configuration
		d.io_sel = addr_hit;
		d.io_offset = 12'h000;
		for (int i = 0; i < resource_routing_pkg::NDEV; i++) begin
			if (addr_hit[i]) begin
				d.io_offset = (i == resource_routing_pkg::DEV_KBD)
					? q.a_sync2 - resource_routing_pkg::KBD_DATA : rel[i];
			end
		end
		d.epp_ok = dev_on[resource_routing_pkg::DEV_PP]
			&& (q.base[resource_routing_pkg::DEV_PP][2:0] == 3'h0);
		// pins nobody selects keep their enable low and float outside
		d.irq_out = 16'h0000;
		d.irq_oe = 16'h0000;
		d.drq_out = 4'h0;
		d.drq_oe = 4'h0;
		d.dack_dev = 6'h00;
		for (int i = 0; i < resource_routing_pkg::NDEV; i++) begin
			if (irq_en[i]) begin
				d.irq_oe[q.irq_sel[i]] = 1'b1;
				d.irq_out[q.irq_sel[i]] = d.irq_out[q.irq_sel[i]] | req.irq[i];
			end
			if (dma_en[i]) begin
				d.drq_oe[q.dma_sel[i][1:0]] = 1'b1;
				d.drq_out[q.dma_sel[i][1:0]] = d.drq_out[q.dma_sel[i][1:0]] | req.drq[i];
				d.dack_dev[i] = q.k_sync2[q.dma_sel[i][1:0]];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.ldn <= resource_routing_pkg::LDN_RST;
			for (int i = 0; i < resource_routing_pkg::NDEV; i++) begin
				q.base[i] <= resource_routing_pkg::BASE_RST;
				q.irq_sel[i] <= resource_routing_pkg::IRQ_SEL_RST;
				q.dma_sel[i] <= resource_routing_pkg::DMA_SEL_RST;
			end
		end else begin
			q <= d;
		end
	end

	// ***************************************************
	// outputs
	// ***************************************************
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp  = q.bresp;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp  = q.rresp;
	assign s_axi_rdata  = {24'h000000, q.rdata};
	assign io_sel       = q.io_sel;
	assign io_offset    = q.io_offset;
	assign dev_powered  = q.act;
	assign epp_ok       = q.epp_ok;
	assign irq_out      = q.irq_out;
	assign irq_oe       = q.irq_oe;
	assign drq_out      = q.drq_out;
	assign drq_oe       = q.drq_oe;
	assign dack_dev     = q.dack_dev;

	// ***************************************************
	// checks
	// ***************************************************
	sequence kbd_access;
		q.s_sync2 && (q.a_sync2 == resource_routing_pkg::KBD_DATA)
			&& dev_on[resource_routing_pkg::DEV_KBD];
	endsequence

	sequence pwr_write;
		wr_fire && q.wstrb0 && (q.awaddr == {2'h0, resource_routing_pkg::IDX_PWR, 2'h0});
	endsequence

	a_reset_selects: assert property (@(posedge aclk) !aresetn |=>
		(q.dma_sel[0] == 3'h4) && (q.irq_sel[0] == 4'h0))
		else $error("selects not at reset values");
	a_irq_line_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		q.irq_oe[0] == 1'b0)
		else $error("interrupt line zero driven");
	a_irq_float_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		(irq_en == 6'h00) |=> (q.irq_oe == 16'h0000))
		else $error("interrupt pin driven with no user");
	a_drq_float_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		(dma_en == 6'h00) |=> (q.drq_oe == 4'h0))
		else $error("dma pin driven with no user");
	a_serial_aux_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!status.modem_aux_output_two[0] |-> !irq_en[resource_routing_pkg::DEV_SP1])
		else $error("serial interrupt without aux output");
	a_ecp_service_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(status.ecp_mode_on && status.ecp_service_interrupt)
		|-> !irq_en[resource_routing_pkg::DEV_PP])
		else $error("parallel interrupt while service bit set");
	a_fdc_dma_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!status.floppy_dma_enable |=> !q.dack_dev[resource_routing_pkg::DEV_FDC])
		else $error("floppy acknowledge while disabled");
	a_bad_base_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		!base_valid[resource_routing_pkg::DEV_SP1] |=> !q.io_sel[resource_routing_pkg::DEV_SP1])
		else $error("serial decoded at illegal base");
	a_kbd_fixed_hit: assert property (@(posedge aclk) disable iff (!aresetn)
		kbd_access |=> q.io_sel[resource_routing_pkg::DEV_KBD] && (q.io_offset == 12'h000))
		else $error("keyboard data address missed");
	a_pwr_act_link: assert property (@(posedge aclk) disable iff (!aresetn)
		pwr_write |=> (q.act == $past(q.wdata[5:0])) ##1 (dev_powered == $past(q.act)))
		else $error("power write did not reach activate");

endmodule

`default_nettype wire

// ==== verilog/resource_routing_pkg.sv ====
package resource_routing_pkg;

	// ***************************************************
	// logical devices and configuration indexes
	// ***************************************************
	localparam int unsigned NDEV    = 6;
	localparam int unsigned DEV_FDC = 0;
	localparam int unsigned DEV_PP  = 1;
	localparam int unsigned DEV_SP1 = 2;
	localparam int unsigned DEV_SP2 = 3;
	localparam int unsigned DEV_KBD = 4;
	localparam int unsigned DEV_PM  = 5;

	localparam logic [5:0][7:0] LDN_NUM = {8'h0a, 8'h07, 8'h05, 8'h04, 8'h03, 8'h00};
	localparam logic [5:0] RELOCATABLE = 6'b101111;
	localparam logic [5:0] HAS_DMA     = 6'b001011;

	localparam logic [7:0] IDX_LDN     = 8'h07;
	localparam logic [7:0] IDX_PWR     = 8'h22;
	localparam logic [7:0] IDX_ACT     = 8'h30;
	localparam logic [7:0] IDX_BASE_HI = 8'h60;
	localparam logic [7:0] IDX_BASE_LO = 8'h61;
	localparam logic [7:0] IDX_IRQ     = 8'h70;
	localparam logic [7:0] IDX_DMA     = 8'h74;

	// ***************************************************
	// reset values
	// ***************************************************
	localparam logic [7:0]  LDN_RST     = 8'h00;
	localparam logic [15:0] BASE_RST    = 16'h0000;
	localparam logic [3:0]  IRQ_SEL_RST = 4'h0;
	localparam logic [2:0]  DMA_SEL_RST = 3'h4;

	// ***************************************************
	// address ranges and offsets
	// ***************************************************
	localparam logic [15:0] STD_MIN     = 16'h0100;
	localparam logic [15:0] STD_MAX     = 16'h0ff8;
	localparam logic [15:0] PP_MAX      = 16'h0ffc;
	localparam logic [15:0] PM_MAX      = 16'h0fe7;
	localparam logic [15:0] PM_SPAN     = 16'h0018;
	localparam logic [11:0] PP_EXT_OFS  = 12'h400;
	localparam logic [11:0] PP_EXT_LAST = 12'h402;
	localparam logic [11:0] KBD_DATA    = 12'h060;
	localparam logic [11:0] KBD_CMD_OFS = 12'h004;

	localparam logic [2:0] ECP_FIFO = 3'b010;
	localparam logic [2:0] ECP_ECP  = 3'b011;
	localparam logic [2:0] ECP_TEST = 3'b110;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ***************************************************
	// carriers
	// ***************************************************
	typedef struct packed {
		logic            floppy_dma_enable;
		logic            printer_irq_enable;
		logic            ecp_mode_on;
		logic [2:0]      ecp_mode;
		logic            ecp_service_interrupt;
		logic            ecp_dma_enable;
		logic [1:0][3:0] uart_int_enable_reg;
		logic [1:0]      modem_aux_output_two;
		logic            uart2_dma_enable;
		logic            kbd_irq_enable;
	} func_status_t;

	typedef struct packed {
		logic [5:0] irq;
		logic [5:0] drq;
	} func_req_t;

	typedef struct packed {
		logic [11:0]      a_sync1;
		logic [11:0]      a_sync2;
		logic             s_sync1;
		logic             s_sync2;
		logic [3:0]       k_sync1;
		logic [3:0]       k_sync2;
		logic [7:0]       ldn;
		logic [5:0]       act;
		logic [5:0][15:0] base;
		logic [5:0][3:0]  irq_sel;
		logic [5:0][2:0]  dma_sel;
		logic             aw_held;
		logic [11:0]      awaddr;
		logic             w_held;
		logic [7:0]       wdata;
		logic             wstrb0;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [7:0]       rdata;
		logic [1:0]       rresp;
		logic [5:0]       io_sel;
		logic [11:0]      io_offset;
		logic [15:0]      irq_out;
		logic [15:0]      irq_oe;
		logic [3:0]       drq_out;
		logic [3:0]       drq_oe;
		logic [5:0]       dack_dev;
		logic             epp_ok;
	} state_t;

endpackage

// ==== verif/isa_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ***************************************************
// host i/o cycles and dma acknowledges
// ***************************************************
module isa_host_model (
	input  wire logic   aclk,
	output logic [11:0] io_addr,
	output logic        io_strobe,
	output logic [3:0]  dack_pins
);
	initial begin
		io_addr   = 12'h000;
		io_strobe = 1'b0;
		dack_pins = 4'h0;
	end

	// address held for the whole strobe; scrambled after so a stale value never decodes
	task automatic io_cycle(input logic [11:0] a, input logic on);
		@(posedge aclk);
		io_addr   <= on ? a : ~io_addr;
		io_strobe <= on;
	endtask

	task automatic ack(input logic [3:0] d);
		@(posedge aclk);
		dack_pins <= d;
	endtask
endmodule

`default_nettype wire

// ==== verif/test_logical_device_resource_routing.sv ====
`timescale 1ns/1ps
`default_nettype none

// ***************************************************
// bench
// ***************************************************
module test_logical_device_resource_routing;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, io_strobe, epp_ok;
	logic [11:0] s_axi_awaddr, s_axi_araddr, io_addr, io_offset;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb, dack_pins, drq_out, drq_oe;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [5:0]  io_sel, dev_powered, dack_dev;
	logic [15:0] irq_out, irq_oe;
	logic [33:0] notes[$];
	logic [31:0] seed = 32'h00013e14;
	int          mismatches = 0;
	int          compares = 0;
	resource_routing_pkg::func_status_t status;
	resource_routing_pkg::func_req_t    req;

	resource_routing dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .io_addr, .io_strobe, .dack_pins, .status,
		.req, .io_sel, .io_offset, .dev_powered, .epp_ok, .irq_out, .irq_oe, .drq_out, .drq_oe,
		.dack_dev);
	isa_host_model host (.aclk, .io_addr, .io_strobe, .dack_pins);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic complete_run;
		if (mismatches == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic hang;
		mismatches++;
		$display("CHECK FAILED %0t wait ran out", $time);
		complete_run();
	endtask

	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic settle;
		repeat (5) @(posedge aclk);
	endtask

	// both channels offered at once; bready held up so the answer is never missed
	// handshakes are judged on settled values half a period before the edge that takes them
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		int   n;
		logic aw_t, w_t, b_t;
		notes.push_back({2'b00, 32'h0});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		b_t = 1'b0;
		while (!b_t && n < 40) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			@(posedge aclk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			n++;
		end
		if (!b_t) hang();
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [1:0] r, input logic [7:0] d);
		int   n;
		logic ar_t, r_t;
		notes.push_back({r, 24'h0, d});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		r_t = 1'b0;
		while (!r_t && n < 40) begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			@(posedge aclk);
			if (ar_t) s_axi_arvalid <= 1'b0;
			n++;
		end
		if (!r_t) hang();
		s_axi_rready <= 1'b0;
	endtask

	task automatic dev(input logic [7:0] l, input logic [15:0] b, input logic [3:0] q);
		wr(12'h01c, l);
		wr(12'h180, b[15:8]);
		wr(12'h184, b[7:0]);
		wr(12'h0c0, 8'h01);
		wr(12'h1c0, {4'h0, q});
	endtask

	always @(negedge aclk) begin
		if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
			if (notes.size() == 0) hang();
			chk(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}, notes.pop_front());
		end
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		status = '0;
		req = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'h1c0, 2'b00, 8'h00);
		rd(12'h1d0, 2'b00, 8'h04);
		rd(12'h188, 2'b00, 8'h00);
		dev(8'h00, 16'h0080, 4'h6);
		host.io_cycle(12'h082, 1'b1);
		settle();
		chk(io_sel, 0);
		wr(12'h180, 8'h03);
		wr(12'h184, 8'hf0);
		rd(12'h180, 2'b00, 8'h03);
		rd(12'h088, 2'b00, 8'h01);
		wr(12'h088, 8'h01);
		rd(12'h0c0, 2'b00, 8'h01);
		host.io_cycle(12'h3f2, 1'b1);
		req.irq[0] <= 1'b1;
		req.drq[0] <= 1'b1;
		settle();
		chk({io_sel, io_offset, dev_powered[0]}, {6'h01, 12'h002, 1'b1});
		chk({irq_oe, drq_oe}, 0);
		status.floppy_dma_enable <= 1'b1;
		// random routing hits the no-channel codes twice but never the zero select
		for (int i = 0; i < 6; i++) begin
			v = xs();
			wr(12'h1c0, {4'h0, v[3:0]});
			wr(12'h1d0, {5'h0, v[6:4]});
			settle();
			chk({irq_oe, irq_out}, v[3:0] == 0 ? 0 : {2{16'h1 << v[3:0]}});
			chk({drq_oe, drq_out}, v[6] ? 0 : {2{4'h1 << v[5:4]}});
		end
		wr(12'h1d0, 8'h02);
		host.ack(4'h4);
		settle();
		chk(dack_dev, 6'h01);
		wr(12'h01c, 8'h07);
		wr(12'h0c0, 8'h01);
		host.io_cycle(12'h064, 1'b1);
		settle();
		chk({io_sel, io_offset}, {6'h10, 12'h004});
		host.io_cycle(12'h060, 1'b1);
		settle();
		chk({io_sel, io_offset}, {6'h10, 12'h000});
		// floppy line is random by now and could land on the parallel line
		status.floppy_dma_enable <= 1'b0;
		dev(8'h03, 16'h0104, 4'h7);
		host.io_cycle(12'h506, 1'b1);
		status.ecp_mode_on <= 1'b1;
		req.irq[1] <= 1'b1;
		settle();
		chk({io_sel, io_offset, epp_ok}, {6'h02, 12'h402, 1'b0});
		for (int m = 0; m < 8; m++) begin
			status.ecp_mode <= 3'(m);
			settle();
			chk(irq_oe[7], m inside {2, 3, 6});
		end
		status.ecp_mode <= 3'h2;
		status.ecp_service_interrupt <= 1'b1;
		settle();
		chk(irq_oe[7], 0);
		complete_run();
	end
endmodule

`default_nettype wire
